/* File: common/cssu_pkg.sv */
// shared constants for the four-way chip-select and wait-state unit
// assumes a single 25 MHz system clock and an AXI4-Lite register port
//
// Function
// - four identical units, own select and termination
// - external master forces A23-A20 zero, code five
// - select asserts at address strobe falling edge
// - each unit has 16-bit base and option
// - base holds code, address, direction, enable
// - direction bit zero reads, one writes
// - disabled never selects, enabled selects on match
// - reset enables unit zero; strap disables, C000
// - registers changeable while unit stays enabled
// - option holds termination, mask, compare enables
// - termination 0-6 waits, seven means external
// - only unmasked address bits are compared
// - direction compare enable gates direction match
// - space compare enable gates function code match
// - strapped unit zero has no pin, still terminates
// - decoding continues for halt-acquired external masters
package cssu_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses on the register bus
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BASE0 = 8'h00; // select_base_0..3 at +4 each
  localparam logic [7:0] OFS_OPT0 = 8'h10; // select_option_0..3 at +4 each
  localparam logic [7:0] OFS_STATUS = 8'h20; // read-only live state
  localparam logic [7:0] OFS_LAST = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BASE_FC_HI = 15; // expected function code 15..13
  localparam int BASE_FC_LO = 13;
  localparam int FLD_ADR_HI = 12; // address or mask bits 12..2
  localparam int FLD_ADR_LO = 2;
  localparam int BASE_DIR = 1; // direction bit
  localparam int BASE_EN = 0; // enable bit
  localparam int OPT_TERM_HI = 15; // termination field 15..13
  localparam int OPT_TERM_LO = 13;
  localparam int OPT_DIRCMP = 1; // direction_compare_enable
  localparam int OPT_SPCCMP = 0; // space_compare_enable

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [15:0] BASE0_RST = 16'h0001; // unit zero enabled
  localparam logic [15:0] BASE_RST = 16'h0000; // other units disabled
  localparam logic [15:0] BASE0_OFF_RST = 16'hC000; // strapped reset value
  localparam logic [15:0] OPT_RST = 16'h0000;
  localparam logic [2:0] TERM_EXT = 3'h7; // peripheral terminates
  localparam logic [2:0] EXT_FC = 3'h5; // forced code for external masters
  localparam logic [3:0] EXT_ADR_TOP = 4'h0; // forced A23-A20
  localparam logic [1:0] STRAP_SETTLE = 2'h3; // cycles before strap is taken
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus cycle sequencer
  typedef enum logic [3:0] {
    CSSU_IDLE = 4'h1,
    CSSU_WAIT = 4'h2,
    CSSU_ACK = 4'h4,
    CSSU_HOLD = 4'h8
  } cssu_phase_e;

endpackage

/* File: rtl/cssu_top.sv */
// four programmable chip-select units with wait-state termination
// assumes bus pins come from outside the clock domain; AXI4-Lite is local
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module cssu_top #(
  parameter int UNITS = 4
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // external bus cycle pins
  input wire logic [23:0] bus_addr,
  input wire logic bus_rnw,
  input wire logic [2:0] bus_fc,
  input wire logic bus_as_n,
  input wire logic ext_master,
  input wire logic core_off_strap,
  // selects and termination
  output logic select_line_0_n,
  output logic [2:0] select_lines_upper_n,
  output logic cycle_ack_n,
  output logic cycle_ack_oe,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] as_sync; // strobe synchroniser chain
    logic [2:0] ext_sync; // external master level chain
    logic [2:0] strap_sync; // strap chain
    logic as_lvl; // filtered strobe level
    logic ext_lvl; // filtered external master level
    logic [1:0] init_cnt; // strap settle counter
    logic init_done; // strap taken
    logic core_off; // latched strap
    logic [UNITS-1:0][15:0] base;
    logic [UNITS-1:0][15:0] opt;
    cssu_pkg::cssu_phase_e phase;
    logic [2:0] ws_cnt; // remaining wait states
    logic [UNITS-1:0] sel_n;
    logic ack_n;
    logic ack_oe;
    logic awready;
    logic wready;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cssu_state_s;

  cssu_state_s st_r;
  cssu_state_s st_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one unit's compare; used for every unit and by the checks
  function automatic logic cssu_match(input logic [15:0] b, input logic [15:0] o,
                                      input logic [23:0] a, input logic rnw,
                                      input logic [2:0] fc);
    logic adr_ok;
    logic dir_ok;
    logic fc_ok;
    adr_ok = ((a[23:13] ^ b[cssu_pkg::FLD_ADR_HI:cssu_pkg::FLD_ADR_LO])
              & o[cssu_pkg::FLD_ADR_HI:cssu_pkg::FLD_ADR_LO]) == 11'h000;
    dir_ok = !o[cssu_pkg::OPT_DIRCMP] || (b[cssu_pkg::BASE_DIR] == !rnw);
    fc_ok = !o[cssu_pkg::OPT_SPCCMP] ||
            (b[cssu_pkg::BASE_FC_HI:cssu_pkg::BASE_FC_LO] == fc);
    return b[cssu_pkg::BASE_EN] && adr_ok && dir_ok && fc_ok;
  endfunction

  // register index from a byte address, or all ones when unmapped
  function automatic logic [3:0] cssu_index(input logic [7:0] addr);
    if (addr[1:0] != 2'h0 || addr > cssu_pkg::OFS_LAST) begin
      return 4'hF;
    end
    return addr[5:2];
  endfunction

  // ---------------------------------------------------------------
  // compare inputs and per-unit hits
  // ---------------------------------------------------------------
  logic [23:0] cmp_addr;
  logic [2:0] cmp_fc;
  logic [UNITS-1:0] hit_w;
  logic as_fall_w;
  logic [2:0] term_w; // termination of the winning unit
  logic any_hit_w;

  // external cycles see forced top bits and code
  // decoding kept for halt-acquired external masters
  assign cmp_addr = st_r.ext_lvl ? {cssu_pkg::EXT_ADR_TOP, bus_addr[19:0]} : bus_addr;
  assign cmp_fc = st_r.ext_lvl ? cssu_pkg::EXT_FC : bus_fc;
  assign as_fall_w = st_r.as_lvl && (st_r.as_sync[1] == st_r.as_sync[2]) &&
                     !st_r.as_sync[2] && st_r.init_done;

  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi++) begin : g_unit
      assign hit_w[gi] = cssu_match(st_r.base[gi], st_r.opt[gi], cmp_addr, bus_rnw, cmp_fc);
    end
  endgenerate

  // lowest matching unit owns the termination
  always_comb begin
    term_w = cssu_pkg::TERM_EXT;
    any_hit_w = |hit_w;
    for (int k = UNITS - 1; k >= 0; k--) begin
      if (hit_w[k]) begin
        term_w = st_r.opt[k][cssu_pkg::OPT_TERM_HI:cssu_pkg::OPT_TERM_LO];
      end
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] widx;
    logic [3:0] ridx;
    logic [15:0] wval;
    logic [15:0] cur;
    widx = 4'h0;
    ridx = 4'h0;
    wval = 16'h0000;
    cur = 16'h0000;
    st_nxt = st_r;

    // pin synchronisers; a change counts once stages two and three agree
    st_nxt.as_sync = {st_r.as_sync[1:0], bus_as_n};
    st_nxt.ext_sync = {st_r.ext_sync[1:0], ext_master};
    st_nxt.strap_sync = {st_r.strap_sync[1:0], core_off_strap};
    if (st_r.as_sync[1] == st_r.as_sync[2]) begin
      st_nxt.as_lvl = st_r.as_sync[2];
    end
    if (st_r.ext_sync[1] == st_r.ext_sync[2]) begin
      st_nxt.ext_lvl = st_r.ext_sync[2];
    end

    // strap taken after release, then reset values set
    if (!st_r.init_done) begin
      if (st_r.init_cnt == cssu_pkg::STRAP_SETTLE) begin
        st_nxt.init_done = 1'b1;
        st_nxt.core_off = st_r.strap_sync[2];
        if (st_r.strap_sync[2]) begin
          st_nxt.base[0] = cssu_pkg::BASE0_OFF_RST;
        end
      end else begin
        st_nxt.init_cnt = st_r.init_cnt + 2'h1;
      end
    end

    // bus cycle sequencer
    case (st_r.phase)
      cssu_pkg::CSSU_IDLE: begin
        if (as_fall_w) begin
          // selects follow the strobe's falling edge
          st_nxt.sel_n = ~hit_w;
          // unit zero pin stays high when strapped
          if (st_r.core_off) begin
            st_nxt.sel_n[0] = 1'b1;
          end
          if (!any_hit_w || term_w == cssu_pkg::TERM_EXT) begin
            st_nxt.phase = cssu_pkg::CSSU_HOLD;
          end else if (term_w == 3'h0) begin
            // no wait states, acknowledge next edge
            st_nxt.phase = cssu_pkg::CSSU_ACK;
            st_nxt.ack_n = 1'b0;
            st_nxt.ack_oe = 1'b1;
          end else begin
            st_nxt.phase = cssu_pkg::CSSU_WAIT;
            st_nxt.ws_cnt = term_w;
          end
        end
      end
      cssu_pkg::CSSU_WAIT: begin
        if (st_r.as_lvl) begin
          // strobe gone early: abandon the cycle
          st_nxt.phase = cssu_pkg::CSSU_IDLE;
          st_nxt.sel_n = '1;
        end else if (st_r.ws_cnt == 3'h1) begin
          st_nxt.phase = cssu_pkg::CSSU_ACK;
          st_nxt.ack_n = 1'b0;
          st_nxt.ack_oe = 1'b1;
        end else begin
          st_nxt.ws_cnt = st_r.ws_cnt - 3'h1;
        end
      end
      cssu_pkg::CSSU_ACK, cssu_pkg::CSSU_HOLD: begin
        // end of cycle: release everything, acknowledge undriven
        if (st_r.as_lvl) begin
          st_nxt.phase = cssu_pkg::CSSU_IDLE;
          st_nxt.sel_n = '1;
          st_nxt.ack_n = 1'b1;
          st_nxt.ack_oe = 1'b0;
          st_nxt.ws_cnt = 3'h0;
        end
      end
      default: begin
        st_nxt.phase = cssu_pkg::CSSU_IDLE;
        st_nxt.sel_n = '1;
        st_nxt.ack_n = 1'b1;
        st_nxt.ack_oe = 1'b0;
      end
    endcase

    // write address and data taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    st_nxt.awready = !st_nxt.aw_held && !st_r.bvalid;
    st_nxt.wready = !st_nxt.w_held && !st_r.bvalid;

    // 16-bit registers in the low half of the word
    // writes land whether or not the unit is enabled
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      widx = cssu_index(st_r.aw_addr);
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = cssu_pkg::RESP_OKAY;
      if (widx < 4'(2 * UNITS)) begin
        cur = widx[2] ? st_r.opt[widx[1:0]] : st_r.base[widx[1:0]];
        wval[7:0] = st_r.w_strb[0] ? st_r.w_data[7:0] : cur[7:0];
        wval[15:8] = st_r.w_strb[1] ? st_r.w_data[15:8] : cur[15:8];
        if (widx[2]) begin
          st_nxt.opt[widx[1:0]] = wval;
        end else begin
          st_nxt.base[widx[1:0]] = wval;
        end
      end else if (widx != 4'(2 * UNITS)) begin
        st_nxt.bresp = cssu_pkg::RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = !st_nxt.aw_held;
      st_nxt.wready = !st_nxt.w_held;
    end

    // read channel, one outstanding
    if (s_axi_arvalid && st_r.arready) begin
      ridx = cssu_index(s_axi_araddr);
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = cssu_pkg::RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (ridx < 4'(2 * UNITS)) begin
        st_nxt.rdata[15:0] = ridx[2] ? st_r.opt[ridx[1:0]] : st_r.base[ridx[1:0]];
      end else if (ridx == 4'(2 * UNITS)) begin
        // live state: selects, acknowledge, phase, strap, external
        st_nxt.rdata[11:0] = {st_r.ext_lvl, st_r.core_off, st_r.phase,
                              st_r.ack_oe, st_r.ack_n, st_r.sel_n};
      end else begin
        st_nxt.rresp = cssu_pkg::RESP_SLVERR;
      end
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // constants only under reset; strap is caught later by init_cnt
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.as_sync <= 3'h7;
      st_r.as_lvl <= 1'b1;
      st_r.base <= '0;
      st_r.base[0] <= cssu_pkg::BASE0_RST;
      st_r.opt <= {UNITS{cssu_pkg::OPT_RST}};
      st_r.phase <= cssu_pkg::CSSU_IDLE;
      st_r.sel_n <= '1;
      st_r.ack_n <= 1'b1;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign select_line_0_n = st_r.sel_n[0];
  assign select_lines_upper_n = st_r.sel_n[3:1];
  assign cycle_ack_n = st_r.ack_n;
  assign cycle_ack_oe = st_r.ack_oe;
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn || !ce);

  logic int_term_w;
  assign int_term_w = any_hit_w && term_w != cssu_pkg::TERM_EXT;

  sequence s_two_waits;
    (!st_r.ack_oe && !st_r.as_lvl)[*2];
  endsequence
  sequence s_ack_on;
    st_r.ack_oe && !st_r.ack_n;
  endsequence

  sel_on_fall_a: assert property (as_fall_w |=> st_r.sel_n[3:1] == ~$past(hit_w[3:1]))
    else $error("selects do not follow the match at strobe fall");
  disabled_quiet_a: assert property (as_fall_w && !st_r.base[1][0] |=> st_r.sel_n[1])
    else $error("disabled unit asserted its select");
  pin0_off_a: assert property (st_r.core_off |-> st_r.sel_n[0])
    else $error("unit zero pin driven while strapped off");
  ext_undriven_a: assert property (st_r.phase == cssu_pkg::CSSU_HOLD |-> !st_r.ack_oe)
    else $error("acknowledge driven under external termination");
  two_waits_a: assert property (as_fall_w && int_term_w && term_w == 3'h2
                                |=> s_two_waits ##1 (s_ack_on or st_r.as_lvl))
    else $error("two wait states not honoured");
  zero_wait_a: assert property (as_fall_w && int_term_w && term_w == 3'h0 |=> s_ack_on)
    else $error("zero wait acknowledge late");
  ext_force_a: assert property (st_r.ext_lvl |-> cmp_addr[23:20] == 4'h0 && cmp_fc == 3'h5)
    else $error("external cycle compare not forced");
  strap_reset_a: assert property ($rose(st_r.init_done) && st_r.core_off
                                  |-> st_r.base[0] == 16'hC000 && !st_r.base[1][0])
    else $error("strapped reset values wrong");
  bresp_hold_a: assert property (st_r.bvalid && !s_axi_bready |=> st_r.bvalid)
    else $error("write response dropped early");
  release_a: assert property ($rose(st_r.as_lvl) && !st_r.phase[0]
                              |=> st_r.sel_n == 4'hF && !st_r.ack_oe)
    else $error("selects not released at strobe rise");

endmodule

`default_nettype wire

/* File: sim/cssu_periph.sv */
// partner model: a slow peripheral that terminates its own cycles
// assumes active-low selects and a pulled-up acknowledge wire
`timescale 1ns/10ps
`default_nettype none

module cssu_periph #(
  parameter int LAT = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // selects seen on the board, units it serves
  input wire logic [3:0] sel_n,
  input wire logic [3:0] slow_units,
  input wire logic dev_oe,
  // acknowledge drive
  output logic ack_n,
  output logic ack_oe
);
  // cycles since a select of a slow unit fell
  int cnt;

  // -------------------------------------------------------------
  // acknowledge after a fixed latency, released with the select
  // -------------------------------------------------------------
  // answer only where device leaves termination
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      ack_oe <= 1'b0;
    end else if (((~sel_n & slow_units) != 4'h0) && !dev_oe) begin
      cnt <= cnt + 1;
      ack_oe <= (cnt >= LAT);
    end else begin
      // off the wire at once, so the pull-up wins
      cnt <= 0;
      ack_oe <= 1'b0;
    end
  end

  // low only while driving; the pull-up covers the rest
  assign ack_n = ~ack_oe;
endmodule

`default_nettype wire

/* File: sim/tb_chip_select_wait_state_unit.sv */
// self-checking bench for the chip-select and wait-state unit
// assumes the design package is compiled first and a 25 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_chip_select_wait_state_unit;
  // stimulus
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic strap = 1'b0;
  logic [23:0] bus_addr = 24'h000000;
  logic [2:0] bus_fc = 3'h0;
  logic bus_rnw = 1'b1;
  logic bus_as_n = 1'b1;
  logic ext_master = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] slow = 4'h0;
  // design outputs and the board wire
  logic sel0, ack_n, ack_oe, awready, wready, bvalid, arready, rvalid, p_ack_n, p_oe;
  logic [2:0] selu;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  wire logic [3:0] sel = {selu, sel0};
  wire logic ack_wire = ack_oe ? ack_n : (p_oe ? p_ack_n : 1'b1);
  // reference register image and counters
  int base[4];
  int opt[4];
  bit strap_m;
  int bad_count = 0;
  int checks = 0;

  always #20 core_clk = ~core_clk;

  cssu_top #(.UNITS(4)) DUT (.core_clk(core_clk), .rstn(rstn), .ce(1'b1),
    .bus_addr(bus_addr), .bus_rnw(bus_rnw), .bus_fc(bus_fc), .bus_as_n(bus_as_n),
    .ext_master(ext_master), .core_off_strap(strap), .select_line_0_n(sel0),
    .select_lines_upper_n(selu), .cycle_ack_n(ack_n), .cycle_ack_oe(ack_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  cssu_periph #(.LAT(2)) PERI (.clk(core_clk), .rstn(rstn), .sel_n(sel),
    .slow_units(slow), .dev_oe(ack_oe), .ack_n(p_ack_n), .ack_oe(p_oe));

  // ---------------------------------------------------------------
  // closing report and bus tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // a wait that runs out ends the run as a failure
  task automatic tmo;
    bad_count++;
    $display("BAD timeout exp 0 got 1");
    wrap_up();
  endtask

  // write: both channels offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask

  // register write with read-back; upper half must read zero
  task automatic wreg(input int u, input bit o, input int v);
    logic [1:0] r;
    logic [31:0] d;
    if (o) opt[u] = v;
    else base[u] = v;
    axw(8'(u * 4 + (o ? 16 : 0)), 16'(v), r);
    `CHK("bresp", 2'h0, r)
    axr(8'(u * 4 + (o ? 16 : 0)), d, r);
    `CHK("readback", {16'h0000, 16'(v)}, d)
  endtask

  // reference decode of one unit
  function automatic bit hit(input int u, input int a, input bit rnw, input int fc, input bit ext);
    int b, o, aa, f;
    b = base[u];
    o = opt[u];
    aa = ext ? (a & 'h0FFFFF) : a;
    f = ext ? 5 : fc;
    if (!b[0]) return 1'b0;
    if ((((aa >> 13) ^ (b >> 2)) & (o >> 2) & 'h7FF) != 0) return 1'b0;
    if (o[1] && (b[1] == rnw)) return 1'b0;
    if (o[0] && (((b >> 13) & 7) != f)) return 1'b0;
    return 1'b1;
  endfunction

  // one bus cycle: strobe low, watch 20 cycles, strobe high, wait release
  task automatic bcyc(input int a, input bit rnw, input int fc, input bit ext);
    logic [3:0] exp_n;
    int w, ns, na;
    bit any, ackd, pa;
    // drive only on a rising edge, whatever edge the caller left on
    @(posedge core_clk);
    exp_n = 4'hF;
    w = 7;
    any = 1'b0;
    for (int u = 3; u >= 0; u--) begin
      slow[u] <= (((opt[u] >> 13) & 7) == 7);
      if (hit(u, a, rnw, fc, ext)) begin
        exp_n[u] = 1'b0;
        w = (opt[u] >> 13) & 7;
        any = 1'b1;
      end
    end
    // unit zero has no pin in the strapped mode
    if (strap_m) exp_n[0] = 1'b1;
    ackd = any && (w != 7);
    bus_addr <= a[23:0];
    bus_rnw <= rnw;
    bus_fc <= fc[2:0];
    ext_master <= ext;
    repeat (5) @(posedge core_clk);
    bus_as_n <= 1'b0;
    ns = -1;
    na = -1;
    pa = 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (ns < 0 && sel !== 4'hF) ns = i;
      if (na < 0 && ack_oe === 1'b1) na = i;
      if (ack_wire === 1'b0) pa = 1'b1;
    end
    `CHK("selects", exp_n, sel)
    `CHK("acked", ackd, na >= 0)
    `CHK("ack_wire", ackd || ((~exp_n & slow) != 4'h0), pa)
    if (ackd && exp_n != 4'hF) `CHK("waits", w, na - ns)
    @(posedge core_clk);
    bus_as_n <= 1'b1;
    for (int i = 0; i < 20 && !(sel === 4'hF && ack_oe === 1'b0); i++) @(negedge core_clk);
    `CHK("released", 5'h0F, {ack_oe, sel})
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int o, b, u, a;
    void'($urandom(32'h97D7F080));
    base = '{1, 0, 0, 0};
    opt = '{0, 0, 0, 0};
    strap_m = 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
    // reset image: only unit zero enabled
    for (int i = 0; i < 8; i++) begin
      axr(8'(i * 4), d, r);
      `CHK("reset_value", (i == 0) ? 32'h1 : 32'h0, d)
    end
    // unmapped places are refused with an error response
    axr(8'h24, d, r);
    `CHK("unmapped_rd", 2'h2, r)
    axw(8'h28, 16'hFFFF, r);
    `CHK("unmapped_wr", 2'h2, r)
    // every termination code on unit zero, match-all region
    for (int t = 0; t < 8; t++) begin
      wreg(0, 1, t << 13);
      bcyc($urandom & 'hFFFFFF, t[0], t, 1'b0);
    end
    // random regions; options before bases, retuned while enabled
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 4; j++) begin
        o = $urandom & 'hFFFF;
        b = ($urandom & 'hFFFE) | int'($urandom % 4 != 0);
        // external masters: no direction or code compare, top bits masked
        // direction compare off
        if (k >= 3) o = o & ~'h1E03;
        wreg(j, 1, o);
        wreg(j, 0, b);
      end
      for (int n = 0; n < 6; n++) begin
        u = $urandom % 4;
        a = ((((base[u] >> 2) & 'h7FF) << 13) | ($urandom & 'h1FFF)) & 'hFFFFFF;
        if ($urandom % 3 == 0) a = $urandom & 'hFFFFFF;
        bcyc(a, $urandom % 2, $urandom % 8, k >= 3);
      end
    end
    // strapped reset: all off, base zero at the fixed value
    @(posedge core_clk);
    rstn <= 1'b0;
    strap <= 1'b1;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
    strap_m = 1'b1;
    base = '{'hC000, 0, 0, 0};
    opt = '{0, 0, 0, 0};
    // every unit disabled, base zero at its strapped value
    for (int i = 0; i < 8; i++) begin
      axr(8'(i * 4), d, r);
      `CHK("strap_reset", (i == 0) ? 32'h0000C000 : 32'h0, d)
    end
    wreg(0, 0, 1);
    bcyc('h123456, 1'b1, 5, 1'b0);
    wrap_up();
  end
endmodule

`default_nettype wire
